// *** rtl/tewc_cfg.svh ***
// Register offsets, field positions, reset values and limits of the timer block
`ifndef TEWC_CFG_SVH
`define TEWC_CFG_SVH

// ********************************************
// Register byte offsets
// ********************************************
`define TEWC_A_CTRL    8'h00
`define TEWC_A_SET     8'h04
`define TEWC_A_CLR     8'h08
`define TEWC_A_EVCTRL  8'h0C
`define TEWC_A_STATUS  8'h10
`define TEWC_A_FLAGS   8'h14
`define TEWC_A_COUNT   8'h18
`define TEWC_A_PERIOD  8'h1C
`define TEWC_A_CC0     8'h20
`define TEWC_A_CC1     8'h24

// ********************************************
// Field positions
// ********************************************
`define TEWC_CTRL_EN   0
`define TEWC_CTRL_MODE 2:1
`define TEWC_CTRL_WAVE 4:3
`define TEWC_CTRL_PSC  7:5
`define TEWC_SET_DIR   0
`define TEWC_SET_ONE   1
`define TEWC_SET_CMD   3:2
`define TEWC_EV_ACT    2:0
`define TEWC_EV_INV    4
`define TEWC_EV_INEN   5
`define TEWC_EV_MCEO   7:6
`define TEWC_EV_CPTEN  9:8
`define TEWC_EV_INVEN  11:10
`define TEWC_ST_RUN    0
`define TEWC_ST_STOP   1
`define TEWC_FL_OVF    0
`define TEWC_FL_MC     2:1
`define TEWC_FL_ERR    3

// ********************************************
// Reset values and counter limits
// ********************************************
`define TEWC_PERIOD_RST 8'hFF
`define TEWC_MAX8       32'h000000FF
`define TEWC_MAX16      32'h0000FFFF
`define TEWC_MAX32      32'hFFFFFFFF
`define TEWC_PSC_SEL1   3'h1

`endif

// *** rtl/tewc_pkg.sv ***
// Types shared by the timer block: modes, event actions, commands, run states
package tewc_pkg;

  typedef enum logic [1:0] {
    mode_8  = 2'b00,
    mode_16 = 2'b01,
    mode_32 = 2'b10
  } tewc_mode_t;

  typedef enum logic [1:0] {
    normal_frequency_op   = 2'b00,
    match_frequency_op    = 2'b01,
    normal_pulse_width_op = 2'b10,
    match_pulse_width_op  = 2'b11
  } tewc_wave_t;

  typedef enum logic [2:0] {
    ev_off                    = 3'b000,
    ev_retrigger              = 3'b001,
    ev_count                  = 3'b010,
    ev_start                  = 3'b011,
    ev_capture                = 3'b100,
    period_then_width_capture = 3'b101,
    width_then_period_capture = 3'b110
  } tewc_evact_t;

  typedef enum logic [1:0] {
    cmd_none    = 2'b00,
    cmd_retrig  = 2'b01,
    cmd_stop    = 2'b10
  } tewc_cmd_t;

  typedef enum logic [1:0] {
    run_idle    = 2'b00,
    run_count   = 2'b01,
    run_stopped = 2'b10
  } tewc_run_t;

endpackage : tewc_pkg

// *** rtl/tewc_prescaler.sv ***
// Prescaler: one-cycle count tick every 1..1024 clocks while the counter runs
`timescale 1ns/1ps
`include "tewc_cfg.svh"

module tewc_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_run,
  input  wire logic [2:0] i_sel,
  output logic            o_tick
);

  // Shift amounts for factors 1, 2, 4, 8, 16, 64, 256, 1024
  localparam logic [3:0] SHIFT [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA};

  logic [9:0] div_q;
  logic [9:0] last;

  // Terminal count of the selected factor, minus one
  assign last   = 10'((11'h001 << SHIFT[i_sel]) - 11'h001);
  assign o_tick = i_run && (div_q == last);

  // Restart from zero whenever counting halts, so a start sees a full period
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 10'h000;
    end else if (!i_run || o_tick) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

endmodule : tewc_prescaler

// *** rtl/tewc_top.sv ***
// Timer/counter with event actions, compare, waveform, capture and single run
//
// What this block does
// [RQ1] Retrigger while running wraps counter to top (down) or zero (up).
// [RQ2] Retrigger while stopped resumes counting from the current count value.
// [RQ3] Retrigger action: enable waits for an event; every later event restarts.
// [RQ4] Count action: each event steps counter up or down per direction.
// [RQ5] Start action: enable waits for event or retrigger; events ignored while running.
// [RQ6] Compare match sets channel flag on the next count tick; event if enabled.
// [RQ7] Four waveform operations select output shaping and the top value.
// [RQ8] Normal ops: top is period in 8-bit mode, counter maximum otherwise.
// [RQ9] Normal frequency: output toggles and flag sets on each channel match.
// [RQ10] Match frequency: channel 0 value is top; output 0 toggles on wrap.
// [RQ11] Normal PWM: set at start/top, clear at match; reversed counting down.
// [RQ12] Match PWM: channel 0 value is top; output 0 pulses low on wrap.
// [RQ13] Prescaler divides by 1, 2, 4, 8, 16, 64, 256 or 1024.
// [RQ14] New top written near zero counting down may reload old top once.
// [RQ15] Lowered top below count counting up is missed; counter runs to maximum.
// [RQ16] Software enables event input and channel capture before any capture.
// [RQ17] Software enables one capture channel for plain timestamp capture.
// [RQ18] Capture into a channel with its flag set is dropped; error flag sets.
// [RQ19] Period/width capture into channels 0/1, swapped in the other mode.
// [RQ20] Invert setting moves period wrap to the falling edge; source asynchronous.
// [RQ21] Software enables channels 0 and 1 together for period and duty.
// [RQ22] Single run stops at next wrap, sets stopped flag, clears outputs.
// [RQ23] Stopped single run restarts on retrigger or start; stopped flag clears.
// [RQ24] Stop command holds count, clears outputs, stops, sets stopped flag.
// [RQ25] Direction set bit counts down; direction clear bit counts up.
`timescale 1ns/1ps
`include "tewc_cfg.svh"

module tewc_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_event,
  output logic      [1:0]  o_wave,
  output logic             o_ovf_event,
  output logic      [1:0]  o_match_event
);

  // ********************************************
  // Bus slave
  // ********************************************
  logic        acc_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic        a_take;
  logic        wr_en;

  // Address phase taken only for word transfers; one wait state follows
  assign a_take = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'h2);
  assign wr_en  = acc_q && wr_q;

  // Data phase is held one cycle so reads see every earlier write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      acc_q  <= a_take;
      wr_q   <= a_take && i_hwrite;
      addr_q <= a_take ? i_haddr[7:0] : addr_q;
    end
  end

  // Register write strobes
  logic w_ctrl;
  logic w_set;
  logic w_clr;
  logic w_ev;
  logic w_flags;
  logic w_count;
  logic w_per;
  logic [1:0] w_cc;
  assign w_ctrl  = wr_en && (addr_q == `TEWC_A_CTRL);
  assign w_set   = wr_en && (addr_q == `TEWC_A_SET);
  assign w_clr   = wr_en && (addr_q == `TEWC_A_CLR);
  assign w_ev    = wr_en && (addr_q == `TEWC_A_EVCTRL);
  assign w_flags = wr_en && (addr_q == `TEWC_A_FLAGS);
  assign w_count = wr_en && (addr_q == `TEWC_A_COUNT);
  assign w_per   = wr_en && (addr_q == `TEWC_A_PERIOD);
  assign w_cc[0] = wr_en && (addr_q == `TEWC_A_CC0);
  assign w_cc[1] = wr_en && (addr_q == `TEWC_A_CC1);

  // ********************************************
  // Configuration registers
  // ********************************************
  logic                  enable_q;
  tewc_pkg::tewc_mode_t  mode_q;
  tewc_pkg::tewc_wave_t  wave_q;
  logic [2:0]            psc_q;
  logic                  dir_q;
  logic                  oneshot_q;
  tewc_pkg::tewc_evact_t evact_q;
  logic                  evinv_q;
  logic                  evin_en_q;
  logic [1:0]            mceo_q;
  logic [1:0]            cpten_q;
  logic [1:0]            inven_q;
  logic [7:0]            period_q;

  // Plain control storage; direction and single run use set/clear writes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_q  <= 1'b0;
      mode_q    <= tewc_pkg::mode_16;
      wave_q    <= tewc_pkg::normal_frequency_op;
      psc_q     <= 3'h0;
      dir_q     <= 1'b0;
      oneshot_q <= 1'b0;
      evact_q   <= tewc_pkg::ev_off;
      evinv_q   <= 1'b0;
      evin_en_q <= 1'b0;
      mceo_q    <= 2'h0;
      cpten_q   <= 2'h0;
      inven_q   <= 2'h0;
      period_q  <= `TEWC_PERIOD_RST;
    end else begin
      if (w_ctrl) begin
        enable_q <= i_hwdata[`TEWC_CTRL_EN];
        mode_q   <= tewc_pkg::tewc_mode_t'(i_hwdata[`TEWC_CTRL_MODE]);
        wave_q   <= tewc_pkg::tewc_wave_t'(i_hwdata[`TEWC_CTRL_WAVE]);
        psc_q    <= i_hwdata[`TEWC_CTRL_PSC];
      end
      if (w_set && i_hwdata[`TEWC_SET_DIR]) dir_q <= 1'b1;         // [RQ25]
      else if (w_clr && i_hwdata[`TEWC_SET_DIR]) dir_q <= 1'b0;    // [RQ25]
      if (w_set && i_hwdata[`TEWC_SET_ONE]) oneshot_q <= 1'b1;     // [RQ22]
      else if (w_clr && i_hwdata[`TEWC_SET_ONE]) oneshot_q <= 1'b0; // [RQ22]
      if (w_ev) begin
        evact_q   <= tewc_pkg::tewc_evact_t'(i_hwdata[`TEWC_EV_ACT]);
        evinv_q   <= i_hwdata[`TEWC_EV_INV];
        evin_en_q <= i_hwdata[`TEWC_EV_INEN];
        mceo_q    <= i_hwdata[`TEWC_EV_MCEO];
        cpten_q   <= i_hwdata[`TEWC_EV_CPTEN];
        inven_q   <= i_hwdata[`TEWC_EV_INVEN];
      end
      if (w_per) period_q <= i_hwdata[7:0];
    end
  end

  // ********************************************
  // Event input and commands
  // ********************************************
  logic ev_prev_q;
  logic ev_lvl;
  logic ev_rise;
  logic ev_fall;
  logic pw_mode;
  logic cmd_retrig;
  logic cmd_stop;
  logic en_rise;

  // Inverting the level moves the wrapping edge to the falling one
  assign ev_lvl     = i_event ^ evinv_q;                       // [RQ20]
  assign ev_rise    = evin_en_q && ev_lvl && !ev_prev_q;
  assign ev_fall    = evin_en_q && !ev_lvl && ev_prev_q;
  assign pw_mode    = (evact_q == tewc_pkg::period_then_width_capture) ||
                      (evact_q == tewc_pkg::width_then_period_capture);
  assign cmd_retrig = w_set && (i_hwdata[`TEWC_SET_CMD] == tewc_pkg::cmd_retrig);
  assign cmd_stop   = w_set && (i_hwdata[`TEWC_SET_CMD] == tewc_pkg::cmd_stop);
  assign en_rise    = w_ctrl && i_hwdata[`TEWC_CTRL_EN] && !enable_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) ev_prev_q <= 1'b0;
    else ev_prev_q <= ev_lvl;
  end

  // Software retrigger or retrigger action share one path
  logic retrig;
  logic start_ev;
  assign retrig   = enable_q && (cmd_retrig ||
                    (ev_rise && evact_q == tewc_pkg::ev_retrigger));
  assign start_ev = enable_q && ev_rise && (evact_q == tewc_pkg::ev_start);

  // ********************************************
  // Counter, top and run state
  // ********************************************
  tewc_pkg::tewc_run_t state_q;
  tewc_pkg::tewc_run_t state_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic [31:0] top_sync_q;
  logic [31:0] top_now;
  logic [31:0] maxv;
  logic        running;
  logic        tick;
  logic        step;
  logic        at_end;
  logic        wrap;
  logic        restart;
  logic        pw_wrap;
  logic [31:0] cc_val [0:1];

  assign running = (state_q == tewc_pkg::run_count);
  assign maxv    = (mode_q == tewc_pkg::mode_8)  ? `TEWC_MAX8 :
                   (mode_q == tewc_pkg::mode_16) ? `TEWC_MAX16 : `TEWC_MAX32;
  // Match ops take channel 0 as top; normal ops use period only in 8-bit mode
  assign top_now = (wave_q == tewc_pkg::match_frequency_op ||
                    wave_q == tewc_pkg::match_pulse_width_op) ? cc_val[0] :  // [RQ10] [RQ12]
                   (mode_q == tewc_pkg::mode_8) ? {24'h000000, period_q} : maxv; // [RQ8]

  tewc_prescaler u_psc (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_run   (running),
    .i_sel   (psc_q),
    .o_tick  (tick)
  ); // [RQ13]

  // Count action steps on events and bypasses the prescaler
  assign step    = running && ((evact_q == tewc_pkg::ev_count) ? ev_rise : tick); // [RQ4]
  // Up count only wraps at top or at maximum, so a top lowered below the count is missed
  assign at_end  = dir_q ? (count_q == 32'h0) : (count_q == top_now || count_q == maxv); // [RQ15]
  assign wrap    = step && at_end;
  assign pw_wrap = running && pw_mode && ev_rise;                                  // [RQ19]
  assign restart = (running && retrig) || pw_wrap;                                 // [RQ1] [RQ3]

  // Reload uses a top lagged one clock, the price of registering the top path
  always_comb begin
    count_d = count_q;
    if (w_count) count_d = i_hwdata & maxv;
    else if (restart || wrap) count_d = dir_q ? top_sync_q : 32'h0;              // [RQ1] [RQ14]
    else if (step) count_d = (dir_q ? count_q - 32'h1 : count_q + 32'h1) & maxv; // [RQ4]
  end

  // Run state: idle after enable for start/retrigger actions, stopped by command or single run
  always_comb begin
    state_d = state_q;
    case (state_q)
      tewc_pkg::run_idle: begin
        if (en_rise && evact_q != tewc_pkg::ev_retrigger && evact_q != tewc_pkg::ev_start)
          state_d = tewc_pkg::run_count;                                 // [RQ3] [RQ5]
        else if (retrig || start_ev)
          state_d = tewc_pkg::run_count;                                 // [RQ2] [RQ5]
      end
      tewc_pkg::run_count: begin
        if (cmd_stop || (wrap && oneshot_q))
          state_d = tewc_pkg::run_stopped;                               // [RQ22] [RQ24]
      end
      tewc_pkg::run_stopped: begin
        if (retrig || start_ev)
          state_d = tewc_pkg::run_count;                                 // [RQ23]
      end
      default: state_d = tewc_pkg::run_idle;
    endcase
    if (w_ctrl && !i_hwdata[`TEWC_CTRL_EN]) state_d = tewc_pkg::run_idle;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q    <= tewc_pkg::run_idle;
      count_q    <= 32'h0;
      top_sync_q <= `TEWC_MAX16;
    end else begin
      state_q    <= state_d;
      count_q    <= count_d;
      top_sync_q <= top_now;                                             // [RQ14]
    end
  end

  // ********************************************
  // Channels: compare, capture, waveform
  // ********************************************
  logic [1:0]  mcf_q;
  logic [1:0]  mc_hit;
  logic [1:0]  cap_ok;
  logic [1:0]  cap_err;
  logic [1:0]  wave_q_int;
  logic [1:0]  wave_d;
  logic        starting;
  logic        period_ch;

  assign starting  = (state_q != tewc_pkg::run_count) && (state_d == tewc_pkg::run_count);
  assign period_ch = (evact_q == tewc_pkg::width_then_period_capture);   // [RQ19]

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [31:0] cc_q;
    logic        cap_ev;
    logic        pw_cap;
    logic        pwm_hold;
    assign cc_val[i] = cc_q;
    // Period channel captures on the wrapping edge, the other on the opposite edge
    assign pw_cap  = pw_mode && running &&
                     ((period_ch == 1'(i)) ? ev_rise : ev_fall);          // [RQ19] [RQ20]
    assign cap_ev  = cpten_q[i] && evin_en_q &&
                     ((evact_q == tewc_pkg::ev_capture && ev_rise) || pw_cap);
    assign cap_ok[i]  = cap_ev && !mcf_q[i];
    assign cap_err[i] = cap_ev && mcf_q[i];                              // [RQ18]
    // Compare is sampled on the count tick that sees equality
    assign mc_hit[i]  = step && !cpten_q[i] && (count_q == cc_q);        // [RQ6]

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) cc_q <= 32'h0;
      else if (cap_ok[i]) cc_q <= count_q;                               // [RQ18]
      else if (w_cc[i]) cc_q <= i_hwdata & maxv;
    end

    // Up counting PWM sets at top and clears at match; down counting reverses
    assign pwm_hold = wrap ? !dir_q : (mc_hit[i] ? dir_q : wave_q_int[i]);  // [RQ11]

    always_comb begin
      wave_d[i] = wave_q_int[i];
      case (wave_q)                                                      // [RQ7]
        tewc_pkg::normal_frequency_op:
          wave_d[i] = wave_q_int[i] ^ mc_hit[i];                         // [RQ9]
        tewc_pkg::match_frequency_op:
          wave_d[i] = wave_q_int[i] ^ ((i == 0) ? wrap : mc_hit[i]);     // [RQ10]
        tewc_pkg::normal_pulse_width_op:
          wave_d[i] = starting ? !dir_q : pwm_hold;                      // [RQ11]
        tewc_pkg::match_pulse_width_op:
          if (i == 0) wave_d[i] = starting ? 1'b1 : (wrap ? 1'b0 : (step ? 1'b1 : wave_q_int[i])); // [RQ12]
          else wave_d[i] = starting ? !dir_q : pwm_hold;
        default: wave_d[i] = 1'b0;
      endcase
      if (state_d != tewc_pkg::run_count) wave_d[i] = 1'b0;            // [RQ22] [RQ24]
    end
  end

  // ********************************************
  // Flags and outputs
  // ********************************************
  logic ovf_q;
  logic err_q;

  // Hardware set wins over a write-one clear landing in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mcf_q <= 2'h0;
      ovf_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      mcf_q <= (mcf_q & ~({2{w_flags}} & i_hwdata[`TEWC_FL_MC])) | mc_hit | cap_ok; // [RQ6] [RQ9]
      ovf_q <= (ovf_q & ~(w_flags && i_hwdata[`TEWC_FL_OVF])) | wrap;
      err_q <= (err_q & ~(w_flags && i_hwdata[`TEWC_FL_ERR])) | (|cap_err);          // [RQ18]
    end
  end

  // Outputs are registered; inversion applies only while counting
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wave_q_int    <= 2'h0;
      o_wave        <= 2'h0;
      o_ovf_event   <= 1'b0;
      o_match_event <= 2'h0;
    end else begin
      wave_q_int    <= wave_d;
      o_wave        <= (state_d == tewc_pkg::run_count) ? (wave_d ^ inven_q) : 2'h0; // [RQ22]
      o_ovf_event   <= wrap;
      o_match_event <= (mc_hit | cap_ok) & mceo_q;                        // [RQ6]
    end
  end

  // ********************************************
  // Read mux and bus answer
  // ********************************************
  logic [31:0] rd_mux;
  assign rd_mux =
    (addr_q == `TEWC_A_CTRL)   ? {24'h0, psc_q, wave_q, mode_q, enable_q} :
    (addr_q == `TEWC_A_SET ||
     addr_q == `TEWC_A_CLR)    ? {30'h0, oneshot_q, dir_q} :
    (addr_q == `TEWC_A_EVCTRL) ? {20'h0, inven_q, cpten_q, mceo_q, evin_en_q, evinv_q, 1'b0, evact_q} :
    (addr_q == `TEWC_A_STATUS) ? {30'h0, state_q == tewc_pkg::run_stopped, running} : // [RQ23]
    (addr_q == `TEWC_A_FLAGS)  ? {28'h0, err_q, mcf_q, ovf_q} :
    (addr_q == `TEWC_A_COUNT)  ? count_q :
    (addr_q == `TEWC_A_PERIOD) ? {24'h0, period_q} :
    (addr_q == `TEWC_A_CC0)    ? cc_val[0] :
    (addr_q == `TEWC_A_CC1)    ? cc_val[1] : 32'h0;

  // First data-phase cycle waits; second answers OKAY with registered data
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata    <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hrdata    <= (acc_q && !wr_q) ? rd_mux : o_hrdata; // Writes leave the last read data standing
      o_hreadyout <= !a_take;
      o_hresp     <= 1'b0;
    end
  end

endmodule : tewc_top

// *** verif/tewc_event_src.sv ***
// Event routing model: drives the timer's single event line with pulses of chosen length
`timescale 1ns/1ps
module tewc_event_src (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_fire,
  input  wire logic [3:0] i_len,
  output logic            o_event
);
  logic [3:0] left_q;
  // Length varies per event so the block sees both short and long levels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      left_q <= 4'h0;
    else if (i_fire)
      left_q <= i_len;
    else if (left_q != 4'h0)
      left_q <= left_q - 4'h1;
  end
  // One line shared by every capture channel, idles low between events
  assign o_event = (left_q != 4'h0);
endmodule : tewc_event_src

// *** verif/tewc_top_assertions.sv ***
// Checker for the timer block's bus answer timing and read data width
`timescale 1ns/1ps
module tewc_top_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_ovf_event
);
  // ****************************************
  // Transfer decode
  // ****************************************
  wire take_w = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);
  wire rd_w   = take_w & ~i_hwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Answer shape: exactly one wait state, data held until the next read lands
  hresp_okay_a: assert property (o_hresp == 1'b0) else $error("hresp not okay");
  ready_wait_a: assert property (take_w |=> !o_hreadyout ##1 o_hreadyout) else $error("no single wait state");
  ready_low_a: assert property (!o_hreadyout |=> o_hreadyout) else $error("hready low too long");
  ready_idle_a: assert property (o_hreadyout && !take_w |=> o_hreadyout) else $error("hready dropped unasked");
  rdata_hold_a: assert property ($changed(o_hrdata) |-> $rose(o_hreadyout)) else $error("hrdata moved");
  write_quiet_a: assert property (take_w && i_hwrite |-> ##2 $stable(o_hrdata)) else $error("write moved hrdata");
  unmapped_zero_a: assert property (rd_w && i_haddr[7:0] > 8'h24 |-> ##2 o_hrdata == 32'h0) else $error("hole not 0");
  status_width_a: assert property (rd_w && i_haddr[7:0] == 8'h10 |-> ##2 o_hrdata[31:2] == 30'h0)
    else $error("status upper bits set");
  period_width_a: assert property (rd_w && i_haddr[7:0] == 8'h1C |-> ##2 o_hrdata[31:8] == 24'h0)
    else $error("period upper bits set");
  // Main scenarios reached
  cover property (rd_w);
  cover property (take_w && i_hwrite);
  cover property (o_ovf_event);
endmodule : tewc_top_assertions
bind tewc_top tewc_top_assertions u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_ovf_event(o_ovf_event));

// *** verif/test_timer_event_wave_capture.sv ***
// Self-checking bench: bus, wrap spans, stop, single run, event counting and capture overflow
`timescale 1ns/1ps
module test_timer_event_wave_capture;
  logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, ev_fire = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, wave, mev;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  ev_len = 4'h1;
  logic        hready, hresp, ovf, ev_line, wa, wb;
  int          mismatches = 0, check_count = 0, cyc = 0, seed = 67, n, top, cc, mev_n = 0;
  always #2.5 clk = ~clk;
  tewc_top i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_event(ev_line), .o_wave(wave), .o_ovf_event(ovf),
    .o_match_event(mev));
  tewc_event_src u_src (.i_clk(clk), .i_rst_b(rst_b), .i_fire(ev_fire), .i_len(ev_len), .o_event(ev_line));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One word transfer; waits on hready rather than a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk iff hready);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge clk iff hready);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk
  function automatic int span(input int sel, input int t);
    int div[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    return div[sel] * (t + 1);
  endfunction : span
  // Random pulse lengths, gap long enough for each edge to be seen apart
  task automatic fire(input int k);
    repeat (k) begin
      ev_len  <= 4'(1 + ($random(seed) & 3));
      ev_fire <= 1'b1;
      @(posedge clk);
      ev_fire <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : fire
  // Cycles between two wrap pulses, with output 0 sampled at each
  task automatic gap();
    @(posedge clk iff ovf);
    wa = wave[0];
    n  = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!ovf);
    wb = wave[0];
  endtask : gap
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (mev[0]) mev_n++; // Channel 0 event pulses, counted for the capture scenario
    if (cyc == 90000) begin
      mismatches++;
      close_out();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk("period_rst", 8'h1C, 32'hFF);
    rchk("ctrl_rst", 8'h00, 32'h2);
    rchk("unmapped", 8'h40, 32'h0);
    // Every prescaler factor, normal and match frequency alternately, 8-bit mode
    for (int s = 0; s < 8; s++) begin
      top = 2 + ($random(seed) & 7);
      cc  = (s & 1) ? top : ($random(seed) & 32'hFF) % (top + 1);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h18, 32'h0); // Leftover count above the new top would run to maximum
      bus(1'b1, 8'h1C, (s & 1) ? 32'hFF : top);
      bus(1'b1, 8'h20, cc);
      bus(1'b1, 8'h00, 32'(s << 5 | (s & 1) << 3 | 1));
      gap();
      chk("wrap_span", span(s, top), n);
      chk("wave_toggle", {31'h0, ~wa}, {31'h0, wb});
    end
    bus(1'b1, 8'h04, 32'h8);
    bus(1'b1, 8'h18, 32'h5);
    rchk("stop_status", 8'h10, 32'h2);
    chk("stop_wave", 32'h0, {30'h0, wave});
    repeat (20) @(posedge clk);
    rchk("stop_hold", 8'h18, 32'h5);
    // Event counting, down then up
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0C, 32'h22);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h18, 32'h5);
    fire(3);
    rchk("count_down", 8'h18, 32'h2);
    bus(1'b1, 8'h08, 32'h1);
    fire(2);
    rchk("count_up", 8'h18, 32'h4);
    // Single run stops at the wrap, retrigger restarts it
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h00, 32'h1);
    @(posedge clk iff ovf);
    repeat (2) @(posedge clk);
    rchk("one_stop", 8'h10, 32'h2);
    chk("one_wave", 32'h0, {30'h0, wave});
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h04, 32'h4);
    rchk("one_restart", 8'h10, 32'h1);
    // Two captures with the flag left set
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b1, 8'h0C, 32'h164);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h14, 32'hF);
    fire(2);
    bus(1'b0, 8'h14, 32'h0);
    chk("capture_err", 32'hA, rd & 32'hA);
    chk("match_event", 32'h1, mev_n);
    // Period then width: one pulse fills both channels without overrun
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0C, 32'h325);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h14, 32'hF);
    fire(1);
    bus(1'b0, 8'h14, 32'h0);
    chk("pw_flags", 32'h6, rd & 32'hE);
    close_out();
  end
endmodule : test_timer_event_wave_capture
